/* cpsc_pkg.sv */
// Constants, register map and types of the charger pin status control block.
// Assumes a single 40 MHz core clock and an APB register port.
//
// Functional notes
// R1 - In ship mode the battery-to-system switch stays open.
// R2 - A low pulse of ship_exit_pulse_time on the control input leaves ship mode.
// R3 - Without input source, 10s low pulse opens switch 310ms, then recloses.
// R4 - Status change or fault gives one 256us low pulse on host_alert_n.
// R5 - Default input current limit: 500mA if source select high, 2.4A if low.
// R6 - Host may overwrite the limit through the 5-bit limit field.
// R7 - input_good_n low only for valid input voltage and limit above 30mA.
// R8 - Charge status pin low while charging.
// R9 - Charge status pin released when charge done or in sleep.
// R10 - Charge status pin blinks at 1Hz, 50% duty on fault suspend.
// R11 - Status pin function field can disable the status pin.
// R12 - direct_charge_enable_out high when its control bit is set.
// R13 - Each data line voltage follows its own 2-bit setting field.
// R14 - Charging enabled only with charge_config_bit 1 and charge_enable_in_n low.
// R15 - Long pulse intervals are timed by a counter; act only after full time.
`default_nettype none
package cpsc_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned SHIP_EXIT_MS = 1000;
   localparam int unsigned RESET_PULSE_MS = 10000;
   localparam int unsigned SWITCH_OFF_MS = 310;
   localparam int unsigned ALERT_US = 256;
   localparam int unsigned BLINK_HALF_MS = 500;
   localparam int unsigned SHIP_EXIT_CYC = SHIP_EXIT_MS * (CLK_HZ / 1000);
   localparam int unsigned RESET_PULSE_CYC = RESET_PULSE_MS * (CLK_HZ / 1000);
   localparam int unsigned SWITCH_OFF_CYC = SWITCH_OFF_MS * (CLK_HZ / 1000);
   localparam int unsigned ALERT_CYC = ALERT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LIMIT = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
   localparam logic [7:0] REG_IRQ_CLR = 8'h10;
   localparam logic [7:0] REG_IRQ_EN = 8'h14;
   // CTRL fields
   localparam int CTRL_CHG_CFG = 0;
   localparam int CTRL_DIRECT_CHG = 1;
   localparam int CTRL_SHIP = 2;
   localparam int CTRL_STATFN_LO = 4;
   localparam int CTRL_DP_LO = 8;
   localparam int CTRL_DM_LO = 12;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   // LIMIT fields: bit 5 marks a host override of the pin default
   localparam int LIM_OVR = 5;
   localparam logic [4:0] LIMIT_500MA = 5'h04;
   localparam logic [4:0] LIMIT_2400MA = 5'h17;
   localparam logic [1:0] STATFN_OFF = 2'h3;
   // Interrupt bits
   localparam int IRQ_STAT_CHG = 0;
   localparam int IRQ_FAULT = 1;
   localparam int IRQ_PWR_RST = 2;
   localparam int IRQ_W = 3;
   typedef enum logic [1:0] {
      SW_ON = 2'b00,
      SW_SHIP = 2'b01,
      SW_RESET_OFF = 2'b10
   } cpsc_sw_t;
endpackage : cpsc_pkg
`default_nettype wire

/* cpsc_sync.sv */
// Two-flop synchroniser for a pin level.
// Assumes the pin is asynchronous to CORE_CLK.
`default_nettype none
module cpsc_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clk, // Core clock
   input wire logic rst, // Async reset, active high
   input wire logic d, // Pin level
   output logic q // Synchronised level
);
   logic meta_q;
   // First flop only feeds the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : cpsc_sync
`default_nettype wire

/* cpsc_blink.sv */
// Free running 1Hz, 50% duty square wave for the status pin.
// Assumes a 40 MHz core clock.
`default_nettype none
module cpsc_blink
   import cpsc_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic rst, // Async reset, active high
   output logic wave // 1Hz square wave
);
   logic [24:0] cnt_q;
   // Toggle every half period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         wave <= 1'b0;
      end else if (cnt_q == 25'(BLINK_HALF_CYC - 1)) begin
         cnt_q <= '0;
         wave <= ~wave; // R10
      end else begin
         cnt_q <= cnt_q + 25'd1;
      end
   end
endmodule : cpsc_blink
`default_nettype wire

/* cpsc_top.sv */
// Pin control and status logic of a single-cell charger, with APB registers.
// Assumes analog monitors give synchronous-to-nothing levels; all are synchronised.
`default_nettype none
module cpsc_top
   import cpsc_pkg::*;
#(
   parameter int unsigned SHIP_EXIT_CYCLES = SHIP_EXIT_CYC,
   parameter int unsigned RESET_PULSE_CYCLES = RESET_PULSE_CYC,
   parameter int unsigned SWITCH_OFF_CYCLES = SWITCH_OFF_CYC,
   parameter int unsigned ALERT_CYCLES = ALERT_CYC
) (
   input wire logic CORE_CLK, // 40 MHz clock
   input wire logic SYS_RST, // Async reset, active high
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB enable
   input wire logic PWRITE, // APB direction
   input wire logic [7:0] PADDR, // APB byte address
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error
   input wire logic SWITCH_CONTROL_IN_N, // Button pin, low active
   input wire logic SOURCE_SELECT_IN, // Source select pin
   input wire logic CHARGE_ENABLE_IN_N, // Charge enable pin, low active
   input wire logic SOURCE_PRESENT, // Input source attached
   input wire logic INPUT_VOLT_OK, // Between UVLO and overvoltage limit
   input wire logic ABOVE_SLEEP, // Above sleep threshold
   input wire logic CHARGING, // Charge in progress
   input wire logic CHARGE_DONE, // Charge complete
   input wire logic CHARGE_FAULT, // Charge suspended on fault
   output logic BATTERY_SYSTEM_SWITCH, // 1 closes battery to system rail
   output logic HOST_ALERT_N_O, // Alert pin drive value
   output logic HOST_ALERT_N_OE, // Alert pin drive enable
   output logic INPUT_GOOD_N_O, // Power good pin drive value
   output logic INPUT_GOOD_N_OE, // Power good pin drive enable
   output logic STATUS_PIN_O, // Status pin drive value
   output logic STATUS_PIN_OE, // Status pin drive enable
   output logic DIRECT_CHARGE_ENABLE_OUT, // External direct charger enable
   output logic CHARGE_ENABLE, // Internal charge enable
   output logic [4:0] INPUT_CURRENT_LIMIT, // Active limit code
   output logic [1:0] PLUS_LINE_VOLTAGE, // D plus voltage select
   output logic [1:0] MINUS_LINE_VOLTAGE, // D minus voltage select
   output logic IRQ // Level interrupt
);
   logic btn_n, psel_pin, ce_n, src, vok, slp, chg, done, flt, blink;
   logic [31:0] ctrl_q;
   logic [5:0] limit_q;
   logic [IRQ_W-1:0] irq_stat_q, irq_en_q;
   wire logic [IRQ_W-1:0] ev;
   cpsc_sw_t sw_q;
   logic [31:0] low_cnt_q, tmr_q, alert_cnt_q;
   logic ship_done_q, rst_done_q, chg_q, flt_q;
   logic wr;

   // Pins from outside are synchronised
   cpsc_sync #(.RST_VAL(1'b1)) u_btn (.clk(CORE_CLK), .rst(SYS_RST), .d(SWITCH_CONTROL_IN_N),
      .q(btn_n));
   cpsc_sync #(.RST_VAL(1'b1)) u_psl (.clk(CORE_CLK), .rst(SYS_RST), .d(SOURCE_SELECT_IN),
      .q(psel_pin));
   cpsc_sync #(.RST_VAL(1'b1)) u_ce (.clk(CORE_CLK), .rst(SYS_RST), .d(CHARGE_ENABLE_IN_N),
      .q(ce_n));
   cpsc_sync #(.RST_VAL(1'b0)) u_src (.clk(CORE_CLK), .rst(SYS_RST), .d(SOURCE_PRESENT),
      .q(src));
   cpsc_sync #(.RST_VAL(1'b0)) u_vok (.clk(CORE_CLK), .rst(SYS_RST), .d(INPUT_VOLT_OK),
      .q(vok));
   cpsc_sync #(.RST_VAL(1'b0)) u_slp (.clk(CORE_CLK), .rst(SYS_RST), .d(ABOVE_SLEEP),
      .q(slp));
   cpsc_sync #(.RST_VAL(1'b0)) u_chg (.clk(CORE_CLK), .rst(SYS_RST), .d(CHARGING),
      .q(chg));
   cpsc_sync #(.RST_VAL(1'b0)) u_dne (.clk(CORE_CLK), .rst(SYS_RST), .d(CHARGE_DONE),
      .q(done));
   cpsc_sync #(.RST_VAL(1'b0)) u_flt (.clk(CORE_CLK), .rst(SYS_RST), .d(CHARGE_FAULT),
      .q(flt));

   cpsc_blink u_blink (.clk(CORE_CLK), .rst(SYS_RST), .wave(blink));

   // APB: zero wait states, access phase completes at once
   assign wr = PSEL && PENABLE && PWRITE;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == REG_CTRL) || (a == REG_LIMIT) || (a == REG_STATUS) ||
         (a == REG_IRQ_STAT) || (a == REG_IRQ_CLR) || (a == REG_IRQ_EN);
   endfunction : addr_ok

   // Control register; ship request bit self clears once taken
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr && PADDR == REG_CTRL) begin
         ctrl_q <= PWDATA & 32'h0000_3337;
      end else if (sw_q == SW_SHIP) begin
         ctrl_q[CTRL_SHIP] <= 1'b0;
      end
   end

   // Limit register; a host write overrides the pin default
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         limit_q <= '0;
      end else if (wr && PADDR == REG_LIMIT) begin
         limit_q <= {1'b1, PWDATA[4:0]}; // R6
      end
   end

   // Interrupt enable register
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         irq_en_q <= '0;
      end else if (wr && PADDR == REG_IRQ_EN) begin
         irq_en_q <= PWDATA[IRQ_W-1:0];
      end
   end

   // Event edges of charge status and fault
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         chg_q <= 1'b0;
         flt_q <= 1'b0;
      end else begin
         chg_q <= chg;
         flt_q <= flt;
      end
   end
   assign ev[IRQ_STAT_CHG] = (chg != chg_q);
   assign ev[IRQ_FAULT] = flt && !flt_q;
   assign ev[IRQ_PWR_RST] = rst_done_q;

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         irq_stat_q <= '0;
      end else if (wr && PADDR == REG_IRQ_CLR) begin
         irq_stat_q <= (irq_stat_q & ~PWDATA[IRQ_W-1:0]) | ev;
      end else begin
         irq_stat_q <= irq_stat_q | ev;
      end
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat_q & irq_en_q);
      end
   end

   // Read data and bus answer
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PRDATA <= '0;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         case (PADDR)
            REG_CTRL: PRDATA <= ctrl_q;
            REG_LIMIT: PRDATA <= {26'h0, limit_q};
            REG_STATUS: PRDATA <= {21'h0, sw_q, INPUT_CURRENT_LIMIT, flt, done, chg, src};
            REG_IRQ_STAT: PRDATA <= {29'h0, irq_stat_q};
            REG_IRQ_EN: PRDATA <= {29'h0, irq_en_q};
            default: PRDATA <= '0;
         endcase
      end
   end
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !addr_ok(PADDR);
      end
   end

   // Low time of the control input, saturating
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         low_cnt_q <= '0;
      end else if (btn_n) begin
         low_cnt_q <= '0;
      end else if (low_cnt_q != 32'hFFFF_FFFF) begin
         low_cnt_q <= low_cnt_q + 32'd1; // R15
      end
   end

   // Switch state machine; one action per held pulse
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sw_q <= SW_ON;
         tmr_q <= '0;
         ship_done_q <= 1'b0;
         rst_done_q <= 1'b0;
      end else begin
         rst_done_q <= 1'b0;
         if (btn_n) begin
            ship_done_q <= 1'b0;
         end
         case (sw_q)
            SW_ON: begin
               if (ctrl_q[CTRL_SHIP]) begin
                  sw_q <= SW_SHIP;
               end else if (!src && !ship_done_q && low_cnt_q == RESET_PULSE_CYCLES) begin
                  sw_q <= SW_RESET_OFF; // R3 R15
                  tmr_q <= '0;
                  ship_done_q <= 1'b1;
               end
            end
            SW_SHIP: begin
               if (low_cnt_q == SHIP_EXIT_CYCLES) begin
                  sw_q <= SW_ON; // R2 R15
                  ship_done_q <= 1'b1;
               end
            end
            SW_RESET_OFF: begin
               if (tmr_q == SWITCH_OFF_CYCLES - 1) begin
                  sw_q <= SW_ON; // R3
                  rst_done_q <= 1'b1;
               end else begin
                  tmr_q <= tmr_q + 32'd1;
               end
            end
            default: sw_q <= SW_ON;
         endcase
      end
   end

   // Switch output: open in ship mode and during reset off time
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         BATTERY_SYSTEM_SWITCH <= 1'b1;
      end else begin
         BATTERY_SYSTEM_SWITCH <= (sw_q == SW_ON); // R1
      end
   end

   // Alert pulse, retriggered by each status change or fault event
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         alert_cnt_q <= '0;
         HOST_ALERT_N_OE <= 1'b0;
      end else if (ev[IRQ_STAT_CHG] || ev[IRQ_FAULT]) begin
         alert_cnt_q <= ALERT_CYCLES - 1; // R4
         HOST_ALERT_N_OE <= 1'b1;
      end else if (alert_cnt_q != 0) begin
         alert_cnt_q <= alert_cnt_q - 32'd1;
      end else begin
         HOST_ALERT_N_OE <= 1'b0;
      end
   end

   // Open drain pins and plain outputs
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         HOST_ALERT_N_O <= 1'b0;
         INPUT_GOOD_N_O <= 1'b0;
         STATUS_PIN_O <= 1'b0;
         INPUT_GOOD_N_OE <= 1'b0;
         STATUS_PIN_OE <= 1'b0;
         DIRECT_CHARGE_ENABLE_OUT <= 1'b0;
         CHARGE_ENABLE <= 1'b0;
         INPUT_CURRENT_LIMIT <= LIMIT_500MA;
         PLUS_LINE_VOLTAGE <= '0;
         MINUS_LINE_VOLTAGE <= '0;
      end else begin
         HOST_ALERT_N_O <= 1'b0;
         INPUT_GOOD_N_O <= 1'b0;
         STATUS_PIN_O <= 1'b0;
         // Limit code 0 is the lowest step, taken as not above 30mA
         INPUT_GOOD_N_OE <= vok && slp && (INPUT_CURRENT_LIMIT != 5'h00); // R7
         if (ctrl_q[CTRL_STATFN_LO +: 2] == STATFN_OFF) begin
            STATUS_PIN_OE <= 1'b0; // R11
         end else if (flt) begin
            STATUS_PIN_OE <= blink; // R10
         end else if (chg && !done && slp) begin
            STATUS_PIN_OE <= 1'b1; // R8
         end else begin
            STATUS_PIN_OE <= 1'b0; // R9
         end
         DIRECT_CHARGE_ENABLE_OUT <= ctrl_q[CTRL_DIRECT_CHG]; // R12
         CHARGE_ENABLE <= ctrl_q[CTRL_CHG_CFG] && !ce_n; // R14
         INPUT_CURRENT_LIMIT <= limit_q[LIM_OVR] ? limit_q[4:0] :
            (psel_pin ? LIMIT_500MA : LIMIT_2400MA); // R5
         PLUS_LINE_VOLTAGE <= ctrl_q[CTRL_DP_LO +: 2]; // R13
         MINUS_LINE_VOLTAGE <= ctrl_q[CTRL_DM_LO +: 2]; // R13
      end
   end

   // Assertions
   ship_open_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R1
      sw_q == SW_SHIP |=> !BATTERY_SYSTEM_SWITCH)
      else $error("switch closed in ship mode");
   ship_exit_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R2
      sw_q == SW_SHIP && !btn_n && low_cnt_q == SHIP_EXIT_CYCLES |=> ##1 BATTERY_SYSTEM_SWITCH)
      else $error("ship exit missed");
   reset_off_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R3
      sw_q == SW_ON && $past(sw_q) == SW_RESET_OFF |-> $past(tmr_q) == SWITCH_OFF_CYCLES - 1)
      else $error("reset off time wrong");
   alert_pulse_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R4
      $rose(HOST_ALERT_N_OE) |-> alert_cnt_q == ALERT_CYCLES - 1)
      else $error("alert pulse length wrong");
   limit_pin_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R5
      !limit_q[LIM_OVR] && $stable(psel_pin) && psel_pin |=> INPUT_CURRENT_LIMIT == LIMIT_500MA)
      else $error("pin limit wrong");
   good_pin_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R7
      !vok |=> !INPUT_GOOD_N_OE)
      else $error("power good with bad input");
   stat_chg_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R8
      chg && !done && slp && !flt && ctrl_q[5:4] != STATFN_OFF |=> STATUS_PIN_OE)
      else $error("status not low while charging");
   stat_off_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R11
      ctrl_q[5:4] == STATFN_OFF |=> !STATUS_PIN_OE)
      else $error("status pin driven while disabled");
   chg_en_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R14
      CHARGE_ENABLE |-> $past(ctrl_q[CTRL_CHG_CFG]) && !$past(ce_n))
      else $error("charge enabled without both conditions");
   // Output checks against their sources, one cycle of register delay, two for the switch
   chg_off_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R14
      !ctrl_q[CTRL_CHG_CFG] || ce_n |=> !CHARGE_ENABLE)
      else $error("charge enabled with a condition missing");
   stat_rel_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R9
      (done || !slp) && !flt |=> !STATUS_PIN_OE)
      else $error("status pin low when done or asleep");
   blink_stat_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R10
      flt && ctrl_q[5:4] != STATFN_OFF |=> STATUS_PIN_OE == $past(blink))
      else $error("status pin not blinking on fault");
   good_on_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R7
      vok && slp && INPUT_CURRENT_LIMIT != 5'h00 |=> INPUT_GOOD_N_OE)
      else $error("power good missing with good input");
   direct_chg_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R12
      1'b1 |=> DIRECT_CHARGE_ENABLE_OUT == $past(ctrl_q[CTRL_DIRECT_CHG]))
      else $error("direct charge enable differs from its bit");
   line_volt_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R13
      1'b1 |=> PLUS_LINE_VOLTAGE == $past(ctrl_q[CTRL_DP_LO +: 2]) &&
      MINUS_LINE_VOLTAGE == $past(ctrl_q[CTRL_DM_LO +: 2]))
      else $error("data line voltage differs from its field");
   limit_ovr_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R6
      limit_q[LIM_OVR] |=> INPUT_CURRENT_LIMIT == $past(limit_q[4:0]))
      else $error("host limit not applied");
   reset_pulse_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // R3
      sw_q == SW_ON && !ctrl_q[CTRL_SHIP] && !src && !ship_done_q &&
      low_cnt_q == RESET_PULSE_CYCLES |=> ##1 !BATTERY_SYSTEM_SWITCH)
      else $error("long pulse did not open the switch");
   cov_ship: cover property (@(posedge CORE_CLK) sw_q == SW_SHIP ##[1:1000] sw_q == SW_ON);
   cov_reset: cover property (@(posedge CORE_CLK) rst_done_q);
   cov_alert: cover property (@(posedge CORE_CLK) $fell(HOST_ALERT_N_OE));
   cov_override: cover property (@(posedge CORE_CLK) limit_q[LIM_OVR] && INPUT_GOOD_N_OE);
endmodule : cpsc_top
`default_nettype wire

/* cpsc_pins_model.sv */
// Far side of the pins: pull-ups on the open-drain lines and a meter for
// the alert pulse. Assumes O/OE pairs where OE high pulls the pin low.
`default_nettype none
module cpsc_pins_model (
   input wire logic clk, // Core clock
   input wire logic rst, // Async reset, active high
   input wire logic ao, // Alert drive value
   input wire logic aoe, // Alert drive enable
   input wire logic go, // Power good drive value
   input wire logic goe, // Power good drive enable
   input wire logic so, // Status drive value
   input wire logic soe, // Status drive enable
   output logic alert_n, // Alert wire level
   output logic good_n, // Power good wire level
   output logic stat_lvl, // Status wire level
   output logic [15:0] aw, // Last alert pulse width
   output logic [15:0] np // Alert pulse count
);
   logic [15:0] run_q;
   // Released lines float up to the pull-up, never the last driven value
   assign alert_n = aoe ? ao : 1'b1;
   assign good_n = goe ? go : 1'b1;
   assign stat_lvl = soe ? so : 1'b1;
   // Host side timer, counts low samples of one pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_q <= '0;
         aw <= '0;
         np <= '0;
      end else if (!alert_n) begin
         run_q <= run_q + 16'h0001;
      end else if (run_q != 16'h0000) begin
         aw <= run_q;
         np <= np + 16'h0001;
         run_q <= '0;
      end
   end
endmodule : cpsc_pins_model
`default_nettype wire

/* cpsc_tb_top.sv */
// Bench of the charger pin block: APB master, pin stimulus, pin model.
// Assumes short count parameters; the 1Hz blink is too slow to watch here.
`default_nettype none
module cpsc_tb_top
   import cpsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEC = 20, RPC = 50, SOC = 10, ALC = 8;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
   logic [7:0] pad = '0;
   logic [31:0] pwd = '0, prd, rd, seed = 32'h0000_241F;
   logic prdy, perr, er, sw, ao, aoe, go, goe, so, soe, dchg, cen, irq;
   logic btn_n = 1, ssel = 1, ce_n = 0, srcp = 0, vok = 1, asl = 1, chg = 0, done = 0;
   logic flt = 0, alert_n, good_n, stat_lvl;
   logic [4:0] lim, v;
   logic [1:0] dp, dm;
   logic [15:0] aw, np, np0;
   int error_cnt = 0, n_checks = 0, cyc = 0, ctrl_m, off;
   cpsc_top #(.SHIP_EXIT_CYCLES(SEC), .RESET_PULSE_CYCLES(RPC), .SWITCH_OFF_CYCLES(SOC),
      .ALERT_CYCLES(ALC)) dut (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(pad), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
      .SWITCH_CONTROL_IN_N(btn_n), .SOURCE_SELECT_IN(ssel), .CHARGE_ENABLE_IN_N(ce_n),
      .SOURCE_PRESENT(srcp), .INPUT_VOLT_OK(vok), .ABOVE_SLEEP(asl), .CHARGING(chg),
      .CHARGE_DONE(done), .CHARGE_FAULT(flt), .BATTERY_SYSTEM_SWITCH(sw),
      .HOST_ALERT_N_O(ao), .HOST_ALERT_N_OE(aoe), .INPUT_GOOD_N_O(go),
      .INPUT_GOOD_N_OE(goe), .STATUS_PIN_O(so), .STATUS_PIN_OE(soe),
      .DIRECT_CHARGE_ENABLE_OUT(dchg), .CHARGE_ENABLE(cen), .INPUT_CURRENT_LIMIT(lim),
      .PLUS_LINE_VOLTAGE(dp), .MINUS_LINE_VOLTAGE(dm), .IRQ(irq));
   cpsc_pins_model pins (.clk(clk), .rst(rst), .ao(ao), .aoe(aoe), .go(go), .goe(goe),
      .so(so), .soe(soe), .alert_n(alert_n), .good_n(good_n), .stat_lvl(stat_lvl),
      .aw(aw), .np(np));
   // 40 MHz clock, reset for four cycles
   always #12.5 clk = ~clk;
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // One APB transfer; waits for ready, only the hang guard ends a dead slave
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pad <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   // Main sequence
   initial begin
      wait (!rst);
      wt(5);
      chk(sw, 1);
      chk(lim, LIMIT_500MA);
      ssel <= 1'b0;
      wt(5);
      chk(lim, LIMIT_2400MA);
      apb(0, REG_CTRL, 0);
      chk(rd, CTRL_RESET);
      apb(0, 8'h40, 0);
      chk(rd, 0);
      chk(er, 1);
      apb(1, 8'h40, 32'hFFFF_FFFF);
      chk(er, 1);
      apb(0, REG_IRQ_CLR, 0);
      chk(rd, 0);
      chk(er, 0);
      // Host limit override, zero code kills power good
      for (int i = 0; i < 5; i++) begin
         v = (i == 4) ? 5'h00 : 5'(xs());
         apb(1, REG_LIMIT, 32'(v));
         wt(4);
         chk(lim, v);
         apb(0, REG_LIMIT, 0);
         chk(rd, 32'h20 | v);
         chk(good_n, v == 0);
      end
      apb(1, REG_LIMIT, 32'h0000_000A);
      for (int i = 0; i < 4; i++) begin
         vok <= i[0];
         asl <= i[1];
         wt(5);
         chk(good_n, i != 3);
      end
      // Each charge bit and enable pin pair and each D minus code; D plus code random
      for (int i = 0; i < 4; i++) begin
         ctrl_m = (i << 12) | ((xs() & 3) << 8) | ((~i & 1) << 1) | (i & 1);
         ce_n <= i[1];
         apb(1, REG_CTRL, ctrl_m);
         wt(4);
         chk(dm, i);
         chk(dp, (ctrl_m >> 8) & 3);
         chk(dchg, !i[0]);
         chk(cen, i == 1);
      end
      apb(1, REG_IRQ_EN, 1);
      np0 = np;
      chg <= 1'b1;
      wt(ALC + 8);
      chk(stat_lvl, 0);
      chk({np, aw}, {np0 + 16'h1, 16'(ALC)});
      chk(irq, 1);
      apb(0, REG_IRQ_STAT, 0);
      chk(rd, 1);
      apb(1, REG_IRQ_CLR, 7);
      wt(2);
      chk(irq, 0);
      done <= 1'b1;
      wt(5);
      chk(stat_lvl, 1);
      done <= 1'b0;
      asl <= 1'b0;
      wt(5);
      chk(stat_lvl, 1);
      asl <= 1'b1;
      apb(1, REG_CTRL, ctrl_m | 32'h30);
      wt(4);
      chk({soe, stat_lvl}, 1);
      apb(1, REG_CTRL, ctrl_m);
      apb(1, REG_IRQ_EN, 0);
      chg <= 1'b0;
      wt(ALC + 8);
      chk(irq, 0);
      flt <= 1'b1;
      wt(ALC + 8);
      chk(np, np0 + 16'h3);
      apb(0, REG_IRQ_STAT, 0);
      chk(rd, 3);
      apb(1, REG_IRQ_EN, 2);
      wt(2);
      chk(irq, 1);
      apb(1, REG_IRQ_CLR, 7);
      flt <= 1'b0;
      // Ship mode, short pulse refused, full pulse exits
      apb(1, REG_CTRL, ctrl_m | 4);
      wt(3);
      chk(sw, 0);
      btn_n <= 1'b0;
      wt(SEC / 2);
      btn_n <= 1'b1;
      wt(SEC);
      chk(sw, 0);
      btn_n <= 1'b0;
      wt(SEC - 2);
      chk(sw, 0);
      wt(10);
      chk(sw, 1);
      btn_n <= 1'b1;
      // Long pulse: power reset without source, refused with one
      for (int s = 0; s < 2; s++) begin
         srcp <= s[0];
         wt(5);
         off = 0;
         btn_n <= 1'b0;
         wt(RPC - 2);
         chk(sw, 1);
         repeat (SOC + 30) begin
            @(posedge clk);
            if (sw !== 1'b1) off++;
         end
         btn_n <= 1'b1;
         chk(off, s ? 0 : SOC);
         apb(0, REG_IRQ_STAT, 0);
         chk(rd, s ? 0 : 4);
         apb(1, REG_IRQ_CLR, 7);
      end
      give_verdict();
   end
endmodule : cpsc_tb_top
`default_nettype wire
